// File: rtl/adcc_conv_ctrl.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module adcc_conv_ctrl #(
    parameter int PINS = 8,
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Analog converter core
    input wire logic [RES_W-1:0] conv_data_in,
    output logic conv_power_on_out,
    output logic conv_reset_out,
    output logic conv_clk_en_out,
    output logic [3:0] conv_channel_out,
    output logic ref_ext_sel_out,
    // Interrupt request
    output logic conv_irq_out,
    // Port pins
    input wire logic [PINS-1:0] port_dir_in,
    input wire logic [PINS-1:0] pullup_in,
    output logic [PINS-1:0] pin_analog_out,
    output logic [PINS-1:0] pin_dir_out,
    output logic [PINS-1:0] pin_pullup_out,
    output logic [PINS-1:0] pin_digital_en_out,
    output logic vref_pin_analog_out
);
    // Software-visible state
    logic start;
    logic [3:0] channel_select;
    logic conv_power_off;
    logic reference_select;
    logic [2:0] conv_clock_div_sel;
    logic [PINS-1:0] analog_pin_enable;
    logic irq_flag;
    logic conv_irq_enable;
    logic mf_irq_enable;
    logic global_irq_enable;
    logic next_start;
    logic [3:0] next_channel_select;
    logic next_conv_power_off;
    logic next_reference_select;
    logic [2:0] next_conv_clock_div_sel;
    logic [PINS-1:0] next_analog_pin_enable;
    logic next_irq_flag;
    logic next_conv_irq_enable;
    logic next_mf_irq_enable;
    logic next_global_irq_enable;

    // Sequencer state
    adcc_pkg::adcc_state_t state;
    adcc_pkg::adcc_state_t next_state;
    logic start_prev;
    logic conv_busy_flag;
    logic next_conv_busy_flag;
    logic [4:0] period_cnt;
    logic [4:0] next_period_cnt;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] next_result;
    logic conv_done;

    // Bus decode
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic setup_rd;
    logic wr_en;
    logic start_rise;
    logic start_fall;
    logic tick;

    // Is the offset one of ours
    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == `ADCC_OFF_CTRL) || (a == `ADCC_OFF_CLKP) || (a == `ADCC_OFF_PINS) ||
               (a == `ADCC_OFF_RESL) || (a == `ADCC_OFF_RESH) || (a == `ADCC_OFF_IRQ);
    endfunction : addr_mapped

    // Zero-wait slave; error only on unmapped offsets
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_mapped(paddr_in);
    assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
    // Registers are byte wide, so only lane 0 carries writes
    assign wr_en = psel_in & penable_in & pwrite_in & pstrb_in[0] & addr_mapped(paddr_in);
    assign prdata_out = rdata;

    // Read data captured in setup so the access phase shows a flop
    always_comb
    begin
        next_rdata = rdata;
        if (setup_rd)
        begin
            next_rdata = 32'h0000_0000;
            unique case (paddr_in)
                `ADCC_OFF_CTRL:
                begin
                    next_rdata[`ADCC_CTRL_START_BIT] = start;
                    next_rdata[`ADCC_CTRL_BUSY_BIT] = conv_busy_flag;
                    next_rdata[`ADCC_CTRL_CH_MSB:0] = channel_select;
                end
                `ADCC_OFF_CLKP:
                begin
                    next_rdata[`ADCC_CLKP_FILL_BIT] = 1'b1;
                    next_rdata[`ADCC_CLKP_PWR_BIT] = conv_power_off;
                    next_rdata[`ADCC_CLKP_REF_BIT] = reference_select;
                    next_rdata[`ADCC_CLKP_DIV_MSB:0] = conv_clock_div_sel;
                end
                `ADCC_OFF_PINS: next_rdata[PINS-1:0] = analog_pin_enable;
                `ADCC_OFF_RESL: next_rdata[7:0] = result[7:0];
                `ADCC_OFF_RESH: next_rdata[RES_W-9:0] = result[RES_W-1:8];
                `ADCC_OFF_IRQ:
                begin
                    next_rdata[`ADCC_IRQ_FLAG_BIT] = irq_flag;
                    next_rdata[`ADCC_IRQ_EN_BIT] = conv_irq_enable;
                    next_rdata[`ADCC_IRQ_MF_BIT] = mf_irq_enable;
                    next_rdata[`ADCC_IRQ_GLB_BIT] = global_irq_enable;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata <= 32'h0000_0000;
        else
            rdata <= next_rdata;
    end

    // Control register writes
    always_comb
    begin
        next_start = start;
        next_channel_select = channel_select;
        next_conv_power_off = conv_power_off;
        next_reference_select = reference_select;
        next_conv_clock_div_sel = conv_clock_div_sel;
        next_analog_pin_enable = analog_pin_enable;
        next_conv_irq_enable = conv_irq_enable;
        next_mf_irq_enable = mf_irq_enable;
        next_global_irq_enable = global_irq_enable;
        if (wr_en && paddr_in == `ADCC_OFF_CTRL)
        begin
            next_start = pwdata_in[`ADCC_CTRL_START_BIT];
            next_channel_select = pwdata_in[`ADCC_CTRL_CH_MSB:0];
        end
        if (wr_en && paddr_in == `ADCC_OFF_CLKP)
        begin
            next_conv_power_off = pwdata_in[`ADCC_CLKP_PWR_BIT];
            next_reference_select = pwdata_in[`ADCC_CLKP_REF_BIT];
            next_conv_clock_div_sel = pwdata_in[`ADCC_CLKP_DIV_MSB:0];
        end
        if (wr_en && paddr_in == `ADCC_OFF_PINS)
            next_analog_pin_enable = pwdata_in[PINS-1:0];
        if (wr_en && paddr_in == `ADCC_OFF_IRQ)
        begin
            next_conv_irq_enable = pwdata_in[`ADCC_IRQ_EN_BIT];
            next_mf_irq_enable = pwdata_in[`ADCC_IRQ_MF_BIT];
            next_global_irq_enable = pwdata_in[`ADCC_IRQ_GLB_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            start <= `ADCC_START_RST;
            channel_select <= `ADCC_CH_RST;
            conv_power_off <= 1'b0;
            reference_select <= 1'b0;
            conv_clock_div_sel <= 3'h0;
            analog_pin_enable <= '0;
            conv_irq_enable <= 1'b0;
            mf_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end
        else
        begin
            start <= next_start;
            channel_select <= next_channel_select;
            conv_power_off <= next_conv_power_off;
            reference_select <= next_reference_select;
            conv_clock_div_sel <= next_conv_clock_div_sel;
            analog_pin_enable <= next_analog_pin_enable;
            conv_irq_enable <= next_conv_irq_enable;
            mf_irq_enable <= next_mf_irq_enable;
            global_irq_enable <= next_global_irq_enable;
        end
    end

    // Start bit edges
    assign start_rise = start & ~start_prev;
    assign start_fall = ~start & start_prev;
    assign conv_done = (state == adcc_pkg::ADCC_CONVERT) && tick &&
                       (period_cnt == `ADCC_CONV_PERIODS - 5'h01);

    // Conversion sequencer
    always_comb
    begin
        next_state = state;
        next_conv_busy_flag = conv_busy_flag;
        next_period_cnt = period_cnt;
        next_result = result;
        unique case (state)
            adcc_pkg::ADCC_IDLE, adcc_pkg::ADCC_CONVERT:
            begin
                if (start_rise)
                begin
                    next_state = adcc_pkg::ADCC_HOLD;
                    next_conv_busy_flag = 1'b1;
                    next_period_cnt = 5'h00;
                end
                else if (conv_done)
                begin
                    next_state = adcc_pkg::ADCC_IDLE;
                    next_conv_busy_flag = 1'b0;
                    next_result = conv_data_in;
                end
                else if (state == adcc_pkg::ADCC_CONVERT && tick)
                    next_period_cnt = period_cnt + 5'h01;
            end
            adcc_pkg::ADCC_HOLD:
            begin
                if (start_fall)
                begin
                    next_state = adcc_pkg::ADCC_CONVERT;
                    next_period_cnt = 5'h00;
                end
            end
            default: next_state = adcc_pkg::ADCC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state <= adcc_pkg::ADCC_IDLE;
            start_prev <= `ADCC_START_RST;
            conv_busy_flag <= `ADCC_BUSY_RST;
            period_cnt <= 5'h00;
            result <= '0;
        end
        else
        begin
            state <= next_state;
            start_prev <= start;
            conv_busy_flag <= next_conv_busy_flag;
            period_cnt <= next_period_cnt;
            result <= next_result;
        end
    end

    // Interrupt flag; completion wins over a software clear
    always_comb
    begin
        next_irq_flag = irq_flag;
        if (wr_en && paddr_in == `ADCC_OFF_IRQ)
            next_irq_flag = irq_flag & pwdata_in[`ADCC_IRQ_FLAG_BIT];
        if (conv_done)
            next_irq_flag = 1'b1;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_flag <= 1'b0;
        else
            irq_flag <= next_irq_flag;
    end

    assign conv_irq_out = irq_flag & conv_irq_enable & mf_irq_enable & global_irq_enable;

    // Converter core controls
    // power is the inverse of the power-off bit
    assign conv_power_on_out = ~conv_power_off;
    assign conv_reset_out = (state == adcc_pkg::ADCC_HOLD);
    assign conv_clk_en_out = tick;
    assign conv_channel_out = channel_select;
    assign ref_ext_sel_out = reference_select;

    // Converter clock enables; unpowered core gets none
    adcc_clk_div u_div (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .div_sel_in(conv_clock_div_sel),
        .run_in(~conv_power_off),
        .restart_in(state == adcc_pkg::ADCC_HOLD),
        .tick_out(tick)
    );

    // Pin function override
    adcc_pin_mux #(
        .PINS(PINS)
    ) u_pins (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .analog_pin_enable_in(analog_pin_enable),
        .port_dir_in(port_dir_in),
        .pullup_in(pullup_in),
        .reference_select_in(reference_select),
        .pin_analog_out(pin_analog_out),
        .pin_dir_out(pin_dir_out),
        .pin_pullup_out(pin_pullup_out),
        .pin_digital_en_out(pin_digital_en_out),
        .vref_pin_analog_out(vref_pin_analog_out)
    );
endmodule : adcc_conv_ctrl
`default_nettype wire

// File: include/adcc_defs.svh
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// Register byte offsets
`define ADCC_OFF_CTRL 12'h000
`define ADCC_OFF_CLKP 12'h004
`define ADCC_OFF_PINS 12'h008
`define ADCC_OFF_RESL 12'h00c
`define ADCC_OFF_RESH 12'h010
`define ADCC_OFF_IRQ 12'h014

// Control register fields
`define ADCC_CTRL_START_BIT 7
`define ADCC_CTRL_BUSY_BIT 6
`define ADCC_CTRL_CH_MSB 3

// Clock and power register fields
`define ADCC_CLKP_FILL_BIT 7
`define ADCC_CLKP_PWR_BIT 6
`define ADCC_CLKP_REF_BIT 5
`define ADCC_CLKP_DIV_MSB 2

// Interrupt register fields
`define ADCC_IRQ_FLAG_BIT 0
`define ADCC_IRQ_EN_BIT 1
`define ADCC_IRQ_MF_BIT 2
`define ADCC_IRQ_GLB_BIT 3

// Clock select codes
`define ADCC_DIV_1 3'h4
`define ADCC_DIV_2 3'h0
`define ADCC_DIV_4 3'h5
`define ADCC_DIV_8 3'h1
`define ADCC_DIV_16 3'h6
`define ADCC_DIV_32 3'h2

// Terminal counts of the divider (ratio minus one)
`define ADCC_LIM_1 5'h00
`define ADCC_LIM_2 5'h01
`define ADCC_LIM_4 5'h03
`define ADCC_LIM_8 5'h07
`define ADCC_LIM_16 5'h0f
`define ADCC_LIM_32 5'h1f

// Conversion length in converter clock periods
`define ADCC_CONV_PERIODS 5'h10

// Reset values
`define ADCC_BUSY_RST 1'b1
`define ADCC_START_RST 1'b0
`define ADCC_CH_RST 4'h0
`define ADCC_BYTE_RST 8'h00

`endif

// File: include/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
    // Conversion sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_HOLD,
        ADCC_CONVERT
    } adcc_state_t;
endpackage : adcc_pkg
`default_nettype wire

// File: rtl/adcc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module adcc_clk_div (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic [2:0] div_sel_in,
    input wire logic run_in,
    input wire logic restart_in,
    // Converter clock enable
    output logic tick_out
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [5:0] lim;

    // Valid flag and terminal count for a select code
    function automatic logic [5:0] div_limit(input logic [2:0] sel);
        logic [5:0] r;
        r = {1'b0, `ADCC_LIM_1};
        unique case (sel)
            `ADCC_DIV_1: r = {1'b1, `ADCC_LIM_1};
            `ADCC_DIV_2: r = {1'b1, `ADCC_LIM_2};
            `ADCC_DIV_4: r = {1'b1, `ADCC_LIM_4};
            `ADCC_DIV_8: r = {1'b1, `ADCC_LIM_8};
            `ADCC_DIV_16: r = {1'b1, `ADCC_LIM_16};
            `ADCC_DIV_32: r = {1'b1, `ADCC_LIM_32};
            default: r = {1'b0, `ADCC_LIM_1};
        endcase
        return r;
    endfunction : div_limit

    assign lim = div_limit(div_sel_in);
    assign tick_out = lim[5] & run_in & ~restart_in & (cnt >= lim[4:0]);

    // Counter; restart aligns the phase to the conversion start
    always_comb
    begin
        next_cnt = cnt;
        if (restart_in || !run_in || !lim[5] || tick_out)
            next_cnt = 5'h00;
        else
            next_cnt = cnt + 5'h01;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cnt <= 5'h00;
        else
            cnt <= next_cnt;
    end
endmodule : adcc_clk_div
`default_nettype wire

// File: rtl/adcc_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_pin_mux #(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Settings
    input wire logic [PINS-1:0] analog_pin_enable_in,
    input wire logic [PINS-1:0] port_dir_in,
    input wire logic [PINS-1:0] pullup_in,
    input wire logic reference_select_in,
    // Effective pin configuration
    output logic [PINS-1:0] pin_analog_out,
    output logic [PINS-1:0] pin_dir_out,
    output logic [PINS-1:0] pin_pullup_out,
    output logic [PINS-1:0] pin_digital_en_out,
    output logic vref_pin_analog_out
);
    logic [PINS-1:0] next_dir;
    logic [PINS-1:0] next_pullup;
    logic [PINS-1:0] next_dig;

    // Analog pins override the port settings
    always_comb
    begin
        next_dir = port_dir_in | analog_pin_enable_in;
        next_pullup = pullup_in & ~analog_pin_enable_in;
        next_dig = ~analog_pin_enable_in;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_analog_out <= '0;
            pin_dir_out <= '0;
            pin_pullup_out <= '0;
            pin_digital_en_out <= '1;
            vref_pin_analog_out <= 1'b0;
        end
        else
        begin
            pin_analog_out <= analog_pin_enable_in;
            pin_dir_out <= next_dir;
            pin_pullup_out <= next_pullup;
            pin_digital_en_out <= next_dig;
            vref_pin_analog_out <= reference_select_in;
        end
    end
endmodule : adcc_pin_mux
`default_nettype wire

// File: dv/adcc_conv_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module adcc_conv_ctrl_checker #(
    parameter int PINS = 8,
    parameter int RES_W = 12
) (
    // Clock, reset and bus
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    // Converter side
    input wire logic conv_power_on_out,
    input wire logic conv_reset_out,
    input wire logic conv_clk_en_out,
    input wire logic ref_ext_sel_out,
    input wire logic conv_irq_out,
    // Pins
    input wire logic [PINS-1:0] port_dir_in,
    input wire logic [PINS-1:0] pullup_in,
    input wire logic [PINS-1:0] pin_analog_out,
    input wire logic [PINS-1:0] pin_dir_out,
    input wire logic [PINS-1:0] pin_pullup_out,
    input wire logic [PINS-1:0] pin_digital_en_out,
    input wire logic vref_pin_analog_out
);
    logic wr_ok;
    logic start_wr;
    logic irq_wr;
    logic [2:0] div_q;
    logic [2:0] next_div_q;
    logic [4:0] tick_q;
    logic [4:0] next_tick_q;

    // Decoded bus writes
    assign wr_ok = psel_in && penable_in && pwrite_in && pstrb_in[0];
    assign start_wr = wr_ok && paddr_in == `ADCC_OFF_CTRL && pwdata_in[7];
    assign irq_wr = wr_ok && paddr_in == `ADCC_OFF_IRQ;

    // Divider code shadow and ticks since the last converter reset
    always_comb
    begin
        next_div_q = div_q;
        next_tick_q = tick_q;
        if (wr_ok && paddr_in == `ADCC_OFF_CLKP)
            next_div_q = pwdata_in[2:0];
        if (conv_reset_out)
            next_tick_q = 5'h00;
        else if (conv_clk_en_out && tick_q != 5'h1f)
            next_tick_q = tick_q + 5'h01;
    end

    // Saturates so that idle ticks cannot wrap into a false count
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            div_q <= 3'h0;
            tick_q <= 5'h00;
        end
        else
        begin
            div_q <= next_div_q;
            tick_q <= next_tick_q;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_PIN_DIR: assert property (
        !$past(sys_rst_in) |-> pin_dir_out == ($past(port_dir_in) | pin_analog_out)) else $error("pin direction wrong");
    AST_PIN_PULL: assert property (
        !$past(sys_rst_in) |-> pin_pullup_out == ($past(pullup_in) & ~pin_analog_out)) else $error("pull-high wrong");
    AST_PIN_DIG: assert property (
        pin_digital_en_out == ~pin_analog_out) else $error("digital enable wrong");
    AST_VREF_PIN: assert property (
        !$past(sys_rst_in) |-> vref_pin_analog_out == $past(ref_ext_sel_out)) else $error("reference pin wrong");
    AST_PWR_STALL: assert property (
        !conv_power_on_out |-> !conv_clk_en_out) else $error("tick while powered off");
    AST_UNDEF_CODE: assert property (
        div_q[1:0] == 2'b11 |-> !conv_clk_en_out) else $error("tick on undefined code");
    AST_IRQ_CAUSE: assert property (
        $rose(conv_irq_out) |-> $past(conv_clk_en_out) || $past(irq_wr)) else $error("interrupt without cause");
    AST_SIXTEEN: assert property (
        $rose(conv_irq_out) && $past(conv_clk_en_out) |-> tick_q == 5'h10) else $error("conversion length wrong");
    AST_RESET_CAUSE: assert property (
        $rose(conv_reset_out) |-> $past(start_wr, 2) || $past(start_wr, 3)) else $error("reset without start");
endmodule : adcc_conv_ctrl_checker

bind adcc_conv_ctrl adcc_conv_ctrl_checker #(.PINS(PINS), .RES_W(RES_W)) chk_u (.ref_clk_in, .sys_rst_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .conv_power_on_out, .conv_reset_out,
    .conv_clk_en_out, .ref_ext_sel_out, .conv_irq_out, .port_dir_in, .pullup_in, .pin_analog_out, .pin_dir_out,
    .pin_pullup_out, .pin_digital_en_out, .vref_pin_analog_out);
`default_nettype wire

// File: dv/adcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Core controls
    input wire logic conv_power_on_in,
    input wire logic [3:0] conv_channel_in,
    input wire logic ref_ext_sel_in,
    // Digitised value
    output logic [11:0] conv_data_out
);
    logic [11:0] junk_q;

    // Unpowered core gives a toggling pattern, never a stale value
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            junk_q <= 12'h5a5;
        else
            junk_q <= ~junk_q;
    end

    always_comb
    begin
        if (conv_power_on_in)
            conv_data_out = ({8'h00, conv_channel_in} * 12'h111) ^ {ref_ext_sel_in, 11'h000};
        else
            conv_data_out = junk_q;
    end
endmodule : adcc_analog_model
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"
module tb;
    typedef struct packed {
        logic [2:0] code;
        logic [3:0] ch;
        logic refx;
        logic [7:0] ratio;
    } adcc_row_t;

    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hf;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, conv_power_on_out, conv_reset_out, conv_clk_en_out, ref_ext_sel_out, conv_irq_out;
    logic [11:0] conv_data_in;
    logic [3:0] conv_channel_out;
    logic [7:0] port_dir_in = 8'h00;
    logic [7:0] pullup_in = 8'h00;
    logic [7:0] pin_analog_out, pin_dir_out, pin_pullup_out, pin_digital_en_out;
    logic vref_pin_analog_out;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    adcc_row_t r;
    logic [11:0] want;
    logic [31:0] q;
    logic e;
    // Every defined clock code at least once, channel codes 0 to 9 in order, then full scale
    adcc_row_t rows [11] = '{'{3'h4, 4'h0, 1'b0, 8'h01}, '{3'h0, 4'h1, 1'b0, 8'h02},
        '{3'h5, 4'h2, 1'b0, 8'h04}, '{3'h1, 4'h3, 1'b0, 8'h08}, '{3'h6, 4'h4, 1'b0, 8'h10},
        '{3'h2, 4'h5, 1'b0, 8'h20}, '{3'h4, 4'h6, 1'b1, 8'h01}, '{3'h0, 4'h7, 1'b0, 8'h02},
        '{3'h5, 4'h8, 1'b0, 8'h04}, '{3'h4, 4'h9, 1'b0, 8'h01}, '{3'h4, 4'hf, 1'b0, 8'h01}};

    adcc_conv_ctrl dut_u (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .conv_data_in, .conv_power_on_out, .conv_reset_out,
        .conv_clk_en_out, .conv_channel_out, .ref_ext_sel_out, .conv_irq_out, .port_dir_in, .pullup_in,
        .pin_analog_out, .pin_dir_out, .pin_pullup_out, .pin_digital_en_out, .vref_pin_analog_out);

    adcc_analog_model model_u (.ref_clk_in, .sys_rst_in, .conv_power_on_in(conv_power_on_out),
        .conv_channel_in(conv_channel_out), .ref_ext_sel_in(ref_ext_sel_out), .conv_data_out(conv_data_in));

    // Clock
    initial forever #5 ref_clk_in = ~ref_clk_in;

    // Hang guard, far above the roughly 1700 cycles the run needs
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // One transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do
            @(posedge ref_clk_in);
        while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdc

    task automatic wait_irq(input int lim);
        n = 0;
        while (conv_irq_out !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk_in);
            n++;
        end
    endtask : wait_irq

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        apb(1'b1, `ADCC_OFF_IRQ, 32'h0e);
        foreach (rows[i])
        begin
            r = rows[i];
            want = ({8'h00, r.ch} * 12'h111) ^ {r.refx, 11'h000};
            // model has no minimum period, so all six defined clock codes are legal here; codes 3 and 7 give no ticks
            apb(1'b1, `ADCC_OFF_CLKP, {26'h0, r.refx, 2'b00, r.code});
            apb(1'b1, `ADCC_OFF_CTRL, {24'h0, 4'h8, r.ch});
            apb(1'b1, `ADCC_OFF_CTRL, {28'h0, r.ch});
            wait_irq(1000);
            chk(n, (n >= 16 * r.ratio - 1 && n <= 16 * r.ratio + 3) ? n : 16 * r.ratio);
            rdc(`ADCC_OFF_CTRL, {28'h0, r.ch});
            rdc(`ADCC_OFF_RESL, {24'h0, want[7:0]});
            rdc(`ADCC_OFF_RESH, {28'h0, want[11:8]});
            apb(1'b1, `ADCC_OFF_IRQ, 32'h0e);
            @(negedge ref_clk_in);
            chk({31'h0, conv_irq_out}, 32'h0);
            $display("row %0d done after %0d cycles", i, n);
        end
        // Pin inputs change on a rising edge like the rest of the stimulus
        @(posedge ref_clk_in);
        port_dir_in <= 8'h0f;
        pullup_in <= 8'hff;
        apb(1'b1, `ADCC_OFF_PINS, 32'ha5);
        apb(1'b1, `ADCC_OFF_CLKP, 32'h24);
        repeat (2) @(negedge ref_clk_in);
        chk({24'h0, pin_dir_out}, 32'haf);
        chk({24'h0, pin_pullup_out}, 32'h5a);
        chk({24'h0, pin_digital_en_out ^ pin_analog_out}, 32'hff);
        chk({24'h0, pin_analog_out}, 32'ha5);
        chk({31'h0, vref_pin_analog_out}, 32'h1);
        $display("pin test done");
        apb(1'b1, `ADCC_OFF_CTRL, 32'h83);
        repeat (40) @(negedge ref_clk_in);
        chk({31'h0, conv_reset_out}, 32'h1);
        rdc(`ADCC_OFF_CTRL, 32'hc3);
        $display("held start test done");
        apb(1'b1, `ADCC_OFF_CLKP, 32'h07);
        apb(1'b1, `ADCC_OFF_CTRL, 32'h03);
        repeat (100) @(negedge ref_clk_in);
        rdc(`ADCC_OFF_CTRL, 32'h43);
        apb(1'b1, `ADCC_OFF_CLKP, 32'h44);
        repeat (50) @(negedge ref_clk_in);
        chk({31'h0, conv_power_on_out}, 32'h0);
        rdc(`ADCC_OFF_CTRL, 32'h43);
        apb(1'b1, `ADCC_OFF_CLKP, 32'h04);
        wait_irq(40);
        chk({31'h0, conv_irq_out}, 32'h1);
        rdc(`ADCC_OFF_RESL, 32'h33);
        apb(1'b1, `ADCC_OFF_IRQ, 32'h0b);
        @(negedge ref_clk_in);
        chk({31'h0, conv_irq_out}, 32'h0);
        rdc(`ADCC_OFF_IRQ, 32'h0b);
        $display("stall test done");
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("unmapped test done");
        apb(1'b1, `ADCC_OFF_CTRL, 32'h85);
        apb(1'b1, `ADCC_OFF_CTRL, 32'h05);
        sys_rst_in <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rdc(`ADCC_OFF_CTRL, 32'h40);
        rdc(`ADCC_OFF_CLKP, 32'h80);
        rdc(`ADCC_OFF_PINS, 32'h00);
        $display("reset test done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
